/* File: gpx_i2c_host.sv */
// Purpose: Two-wire bus host model driving the expander's serial pins.
// Assumes: SDA has a pull-up; every pin change follows an mclk edge.
// Notes:   The bench calls the tasks by hierarchical name.
`timescale 1ns/1ps
module gpx_i2c_host (
    input  wire logic mclk,
    input  wire logic sdaOe,
    input  wire logic sdaOut,
    output var  logic scl,
    output wire logic sdaLine
);
    localparam int Q = 25; // Quarter bit in mclk cycles keeps 400kHz
    logic sdaLow;

    // Pull-up wins unless a party pulls low
    assign sdaLine = !(sdaLow || (sdaOe && !sdaOut));

    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    task automatic q(input int n);
        repeat (n * Q) @(posedge mclk);
    endtask : q

    // Data changes mid-low, so setup and hold both span a quarter bit
    task automatic bitx(input logic b, output logic r);
        sdaLow <= !b;
        q(1);
        scl <= 1'b1;
        q(1);
        r = sdaLine;
        q(1);
        scl <= 1'b0;
        q(1);
    endtask : bitx

    // Also serves as repeated start
    task automatic start();
        sdaLow <= 1'b0;
        q(1);
        scl <= 1'b1;
        q(1);
        sdaLow <= 1'b1;
        q(1);
        scl <= 1'b0;
        q(1);
    endtask : start

    task automatic stop();
        sdaLow <= 1'b1;
        q(1);
        scl <= 1'b1;
        q(1);
        sdaLow <= 1'b0;
        q(2);
    endtask : stop

    // Eight bits MSB first, then the acknowledge bit
    task automatic xfer(input logic [7:0] tx, input logic mAck, output logic [7:0] rx,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(tx[i], r);
            rx[i] = r;
        end
        bitx(mAck, ack);
    endtask : xfer
endmodule : gpx_i2c_host

/* File: gpx_pkg.sv */
// Purpose: Constants and types shared by the GPIO expander port/config block.
// Assumes: 40 MHz mclk; serial bus pins sampled asynchronously.
// Notes:   Offsets, reset values and most field positions live here; the status bits 1:0 are fixed in the block.
package gpx_pkg;

    localparam int NPORT = 9;

    // Register map
    localparam logic [7:0] REG_PORT_FIRST = 8'h01;
    localparam logic [7:0] REG_PORT_LAST  = 8'h09;
    localparam logic [7:0] REG_PIN_CFG    = 8'h27;
    localparam logic [7:0] PORT_RESET     = 8'h80;
    localparam logic [7:0] PINCFG_RESET   = 8'h8F;
    localparam logic [7:0] RD_UNMAPPED    = 8'h00;

    // Port register fields
    localparam int B_DIR = 7;
    localparam int B_D6  = 6;
    localparam int B_D5  = 5;
    localparam int B_DEB = 2;

    // Pin-function configuration fields
    localparam int CFG_TMO    = 7;
    localparam int CFG_CLOCK_OUT_PIN_FUNCTION = 3;
    localparam int CFG_CLOCK_IN_PIN_FUNCTION  = 2;
    localparam int CFG_INT    = 1;

    // Port numbers with special functions (zero based)
    localparam logic [3:0] PN_ONE   = 4'h0;
    localparam logic [3:0] PN_TWO   = 4'h1;
    localparam logic [3:0] PN_THREE = 4'h2;

    // Slave address
    localparam logic [4:0] ADDR_PREFIX = 5'h13;
    localparam logic [1:0] SEL_GND = 2'h0;
    localparam logic [1:0] SEL_VDD = 2'h1;
    localparam logic [1:0] SEL_SCL = 2'h2;
    localparam logic [1:0] SEL_SDA = 2'h3;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [3:0] BITS_LAST = 4'h7;

    // Timing
    localparam longint CLK_HZ   = 40000000;
    localparam longint DEB_MS   = 31;
    localparam longint TMO_MS   = 25;
    localparam int     DEB_CYC  = int'((DEB_MS * CLK_HZ) / 1000);
    localparam int     TMO_CYC  = int'((TMO_MS * CLK_HZ) / 1000);
    localparam int     CNT_W    = 24;

    typedef logic [NPORT-1:0]      gpx_pvec_t;
    typedef logic [NPORT-1:0][7:0] gpx_ctl_t;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_ADDR     = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_REG      = 4'h3,
        ST_REG_ACK  = 4'h4,
        ST_WDATA    = 4'h5,
        ST_WACK     = 4'h6,
        ST_RDATA    = 4'h7,
        ST_RACK     = 4'h8
    } gpx_st_t;

    // Whole state of the block
    typedef struct packed {
        logic             sclS1;
        logic             sclS2;
        logic             sclD;
        logic             sdaS1;
        logic             sdaS2;
        logic             sdaD;
        logic             selS1;
        logic             selS2;
        logic             oscS1;
        logic             oscS2;
        gpx_pvec_t        pinS1;
        gpx_pvec_t        pinS2;
        gpx_st_t          fsm;
        logic [3:0]       bitCnt;
        logic [7:0]       shift;
        logic [7:0]       regAddr;
        logic             rw;
        logic             more;
        logic             neSda;
        logic             neScl;
        logic             seenLo;
        gpx_ctl_t         ctl;
        logic [7:0]       pinCfg;
        gpx_pvec_t        snap;
        gpx_pvec_t        trn;
        gpx_pvec_t        debPrev;
        gpx_pvec_t        debLvl;
        logic [CNT_W-1:0] debCnt;
        logic [CNT_W-1:0] tmoCnt;
        logic             sdaO;
        logic             sdaE;
        gpx_pvec_t        portO;
        gpx_pvec_t        portE;
        logic             oscExt;
    } gpx_state_t;

endpackage : gpx_pkg

/* File: gpx_port_config.sv */
// Purpose: Serial target, port control registers, pin-function config,
//          transition detection, debounce and pin drive of the expander.
// Assumes: PWM/blink engine outside supplies pwmLevel on mclk; the internal
//          oscillator arrives on oscClk from another domain.
// Notes:   All state is one struct; outputs come straight from it.
`timescale 1ns/1ps
module gpx_port_config #(
    parameter int DEB_CYCLES = gpx_pkg::DEB_CYC,
    parameter int TMO_CYCLES = gpx_pkg::TMO_CYC
) (
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic              scl,
    input  wire logic              sdaIn,
    output wire logic              sdaOut,
    output wire logic              sdaOe,
    input  wire logic              addrSelPin,
    input  wire logic              oscClk,
    input  wire gpx_pkg::gpx_pvec_t portIn,
    input  wire gpx_pkg::gpx_pvec_t pwmLevel,
    output wire gpx_pkg::gpx_pvec_t portOut,
    output wire gpx_pkg::gpx_pvec_t portOe,
    output wire gpx_pkg::gpx_ctl_t  portCtl,
    output wire logic [7:0]        pinCfg,
    output wire logic              oscExtIn
);

    gpx_pkg::gpx_state_t s_reg;
    gpx_pkg::gpx_state_t s_next;

    logic               sclRise;
    logic               sclFall;
    logic               startCond;
    logic               stopCond;
    logic [1:0]         selBits;
    logic               tick;
    logic               intAct;
    logic [7:0]         rdVal;
    gpx_pkg::gpx_pvec_t lvl;
    gpx_pkg::gpx_pvec_t isIn;

    // True when the address selects one of the port registers
    function automatic logic portHit(input logic [7:0] a);
        return (a >= gpx_pkg::REG_PORT_FIRST) && (a <= gpx_pkg::REG_PORT_LAST);
    endfunction : portHit

    // Zero-based port number for a port register address
    function automatic logic [3:0] portNum(input logic [7:0] a);
        logic [7:0] d;
        d = a - gpx_pkg::REG_PORT_FIRST;
        return d[3:0];
    endfunction : portNum

    // Pin events derived from the second synchroniser stage only
    assign sclRise   = s_reg.sclS2 & ~s_reg.sclD;
    assign sclFall   = ~s_reg.sclS2 & s_reg.sclD;
    assign startCond = s_reg.sclS2 & s_reg.sclD & s_reg.sdaD & ~s_reg.sdaS2;
    assign stopCond  = s_reg.sclS2 & s_reg.sclD & ~s_reg.sdaD & s_reg.sdaS2;
    assign tick      = (s_reg.debCnt == gpx_pkg::CNT_W'(DEB_CYCLES - 1));

    // Select pin follows SDA, else SCL, else held high, else ground
    always_comb begin
        if (!s_reg.neSda) begin
            selBits = gpx_pkg::SEL_SDA;
        end else if (!s_reg.neScl) begin
            selBits = gpx_pkg::SEL_SCL;
        end else if (!s_reg.seenLo) begin
            selBits = gpx_pkg::SEL_VDD;
        end else begin
            selBits = gpx_pkg::SEL_GND;
        end
    end

    // Per-port view: direction and the level seen by reads and detection
    always_comb begin
        for (int i = 0; i < gpx_pkg::NPORT; i++) begin
            isIn[i] = s_reg.ctl[i][gpx_pkg::B_DIR];
            lvl[i]  = s_reg.ctl[i][gpx_pkg::B_DEB] ? s_reg.debLvl[i]
                                                   : s_reg.pinS2[i];
        end
        isIn[gpx_pkg::PN_TWO] = isIn[gpx_pkg::PN_TWO]
                              & s_reg.pinCfg[gpx_pkg::CFG_CLOCK_IN_PIN_FUNCTION];
        isIn[gpx_pkg::PN_THREE] = isIn[gpx_pkg::PN_THREE]
                                & s_reg.pinCfg[gpx_pkg::CFG_CLOCK_OUT_PIN_FUNCTION];
        intAct = 1'b0;
        for (int i = 0; i < gpx_pkg::NPORT; i++) begin
            intAct = intAct | (s_reg.trn[i] & isIn[i]
                             & s_reg.ctl[i][gpx_pkg::B_D5]);
        end
    end

    // Readback of the register at the current address
    always_comb begin
        rdVal = gpx_pkg::RD_UNMAPPED;
        if (portHit(s_reg.regAddr)) begin
            rdVal = s_reg.ctl[portNum(s_reg.regAddr)];
            if (s_reg.ctl[portNum(s_reg.regAddr)][gpx_pkg::B_DIR]) begin
                // Status bits come from live state, never from stored writes
                rdVal[1] = s_reg.trn[portNum(s_reg.regAddr)];
                rdVal[0] = lvl[portNum(s_reg.regAddr)];
            end
        end else if (s_reg.regAddr == gpx_pkg::REG_PIN_CFG) begin
            rdVal = s_reg.pinCfg;
        end
    end

    // Next-state logic for the whole block
    always_comb begin
        s_next = s_reg;

        // Two-stage synchronisers for every foreign input
        s_next.sclS1 = scl;
        s_next.sclS2 = s_reg.sclS1;
        s_next.sclD  = s_reg.sclS2;
        s_next.sdaS1 = sdaIn;
        s_next.sdaS2 = s_reg.sdaS1;
        s_next.sdaD  = s_reg.sdaS2;
        s_next.selS1 = addrSelPin;
        s_next.selS2 = s_reg.selS1;
        s_next.oscS1 = oscClk;
        s_next.oscS2 = s_reg.oscS1;
        s_next.pinS1 = portIn;
        s_next.pinS2 = s_reg.pinS1;

        // Select-pin tracking, restarted at each start so address can move
        s_next.neSda  = s_reg.neSda | (s_reg.selS2 != s_reg.sdaS2);
        s_next.neScl  = s_reg.neScl | (s_reg.selS2 != s_reg.sclS2);
        s_next.seenLo = s_reg.seenLo | ~s_reg.selS2;

        // Debounce sampler: one shared 31 ms tick for all ports
        s_next.debCnt = tick ? '0 : s_reg.debCnt + 1'b1;
        for (int i = 0; i < gpx_pkg::NPORT; i++) begin
            if (!s_reg.ctl[i][gpx_pkg::B_DEB]) begin
                // Follow the pin so enabling debounce starts from truth
                s_next.debLvl[i]  = s_reg.pinS2[i];
                s_next.debPrev[i] = s_reg.pinS2[i];
            end else if (tick) begin
                s_next.debPrev[i] = s_reg.pinS2[i];
                if (s_reg.pinS2[i] == s_reg.debPrev[i]) begin
                    s_next.debLvl[i] = s_reg.pinS2[i];
                end
            end
            // Change against the snapshot of the last read sets the flag
            if (isIn[i] && (lvl[i] != s_reg.snap[i])) begin
                s_next.trn[i] = 1'b1;
            end
        end

        // Serial target: shift in on the rising edge of SCL
        if (sclRise) begin
            // Only receiving states shift; a read byte must move on the fall alone
            if (s_reg.fsm == gpx_pkg::ST_ADDR || s_reg.fsm == gpx_pkg::ST_REG
                || s_reg.fsm == gpx_pkg::ST_WDATA) begin
                s_next.shift  = {s_reg.shift[6:0], s_reg.sdaS2};
                s_next.bitCnt = s_reg.bitCnt + 4'h1;
            end
            if (s_reg.fsm == gpx_pkg::ST_RACK) begin
                s_next.more = ~s_reg.sdaS2;
            end
        end

        // Serial target: act and move SDA on the falling edge of SCL
        if (sclFall) begin
            unique case (s_reg.fsm)
                gpx_pkg::ST_IDLE: begin
                    s_next.sdaE = 1'b0;
                end
                gpx_pkg::ST_ADDR: begin
                    if (s_reg.bitCnt == gpx_pkg::BITS_BYTE) begin
                        s_next.bitCnt = '0;
                        if (s_reg.shift[7:1] == {gpx_pkg::ADDR_PREFIX, selBits}) begin
                            s_next.rw   = s_reg.shift[0];
                            s_next.fsm  = gpx_pkg::ST_ADDR_ACK;
                            s_next.sdaE = 1'b1;
                        end else begin
                            s_next.fsm = gpx_pkg::ST_IDLE;
                        end
                    end
                end
                gpx_pkg::ST_ADDR_ACK: begin
                    if (s_reg.rw) begin
                        s_next.fsm = gpx_pkg::ST_RDATA;
                    end else begin
                        s_next.fsm  = gpx_pkg::ST_REG;
                        s_next.sdaE = 1'b0;
                    end
                end
                gpx_pkg::ST_REG: begin
                    if (s_reg.bitCnt == gpx_pkg::BITS_BYTE) begin
                        s_next.bitCnt  = '0;
                        s_next.regAddr = s_reg.shift;
                        s_next.fsm     = gpx_pkg::ST_REG_ACK;
                        s_next.sdaE    = 1'b1;
                    end
                end
                gpx_pkg::ST_REG_ACK, gpx_pkg::ST_WACK: begin
                    s_next.fsm  = gpx_pkg::ST_WDATA;
                    s_next.sdaE = 1'b0;
                end
                gpx_pkg::ST_WDATA: begin
                    if (s_reg.bitCnt == gpx_pkg::BITS_BYTE) begin
                        s_next.bitCnt  = '0;
                        s_next.fsm     = gpx_pkg::ST_WACK;
                        s_next.sdaE    = 1'b1;
                        s_next.regAddr = s_reg.regAddr + 8'h01;
                        if (portHit(s_reg.regAddr)) begin
                            s_next.ctl[portNum(s_reg.regAddr)] = s_reg.shift;
                        end else if (s_reg.regAddr == gpx_pkg::REG_PIN_CFG) begin
                            s_next.pinCfg = s_reg.shift;
                        end
                    end
                end
                gpx_pkg::ST_RDATA: begin
                    if (s_reg.bitCnt == gpx_pkg::BITS_LAST) begin
                        s_next.bitCnt = '0;
                        s_next.fsm    = gpx_pkg::ST_RACK;
                        s_next.sdaE   = 1'b0;
                    end else begin
                        s_next.bitCnt = s_reg.bitCnt + 4'h1;
                        s_next.shift  = {s_reg.shift[6:0], 1'b0};
                        s_next.sdaE   = ~s_reg.shift[6];
                    end
                end
                gpx_pkg::ST_RACK: begin
                    if (s_reg.more) begin
                        s_next.fsm = gpx_pkg::ST_RDATA;
                    end else begin
                        s_next.fsm = gpx_pkg::ST_IDLE;
                    end
                end
                default: begin
                    s_next.fsm  = gpx_pkg::ST_IDLE;
                    s_next.sdaE = 1'b0;
                end
            endcase
            // Load a read byte; loading a port register counts as its read
            if ((s_reg.fsm == gpx_pkg::ST_ADDR_ACK && s_reg.rw)
                || (s_reg.fsm == gpx_pkg::ST_RACK && s_reg.more)) begin
                s_next.shift   = rdVal;
                s_next.sdaE    = ~rdVal[7];
                s_next.regAddr = s_reg.regAddr + 8'h01;
                if (portHit(s_reg.regAddr)) begin
                    // Snapshot taken with the clear, so no change slips past
                    s_next.trn[portNum(s_reg.regAddr)]  = 1'b0;
                    s_next.snap[portNum(s_reg.regAddr)] = lvl[portNum(s_reg.regAddr)];
                end
            end
        end

        // Start and stop override any byte in flight
        if (startCond) begin
            s_next.fsm    = gpx_pkg::ST_ADDR;
            s_next.bitCnt = '0;
            s_next.sdaE   = 1'b0;
            s_next.neSda  = 1'b0;
            s_next.neScl  = 1'b0;
            s_next.seenLo = 1'b0;
        end else if (stopCond) begin
            s_next.fsm  = gpx_pkg::ST_IDLE;
            s_next.sdaE = 1'b0;
        end

        // Bus timeout: SCL held low too long releases the bus
        if (!s_reg.pinCfg[gpx_pkg::CFG_TMO] && s_reg.fsm != gpx_pkg::ST_IDLE
            && !s_reg.sclS2) begin
            s_next.tmoCnt = s_reg.tmoCnt + 1'b1;
            if (s_reg.tmoCnt == gpx_pkg::CNT_W'(TMO_CYCLES - 1)) begin
                s_next.fsm    = gpx_pkg::ST_IDLE;
                s_next.sdaE   = 1'b0;
                s_next.tmoCnt = '0;
            end
        end else begin
            s_next.tmoCnt = '0;
        end

        // Pin drive; PWM level comes from the external engine
        for (int i = 0; i < gpx_pkg::NPORT; i++) begin
            if (s_reg.ctl[i][gpx_pkg::B_DIR]) begin
                s_next.portE[i] = 1'b0;
                s_next.portO[i] = 1'b0;
            end else begin
                s_next.portO[i] = pwmLevel[i];
                s_next.portE[i] = ~pwmLevel[i]
                                | s_reg.ctl[i][gpx_pkg::B_D6];
            end
        end
        if (!s_reg.ctl[gpx_pkg::PN_ONE][gpx_pkg::B_DIR]) begin
            // Port one can only sink
            s_next.portO[gpx_pkg::PN_ONE] = 1'b0;
            s_next.portE[gpx_pkg::PN_ONE] = ~pwmLevel[gpx_pkg::PN_ONE];
        end
        if (!s_reg.pinCfg[gpx_pkg::CFG_INT]) begin
            s_next.portO[gpx_pkg::PN_ONE] = 1'b0;
            s_next.portE[gpx_pkg::PN_ONE] = intAct;
        end
        if (!s_reg.pinCfg[gpx_pkg::CFG_CLOCK_IN_PIN_FUNCTION]) begin
            s_next.portO[gpx_pkg::PN_TWO] = 1'b0;
            s_next.portE[gpx_pkg::PN_TWO] = 1'b0;
        end
        if (!s_reg.pinCfg[gpx_pkg::CFG_CLOCK_OUT_PIN_FUNCTION]) begin
            s_next.portO[gpx_pkg::PN_THREE] = s_reg.oscS2;
            s_next.portE[gpx_pkg::PN_THREE] = 1'b1;
        end
        s_next.oscExt = ~s_reg.pinCfg[gpx_pkg::CFG_CLOCK_IN_PIN_FUNCTION]
                      & s_reg.pinS2[gpx_pkg::PN_TWO];
        s_next.sdaO   = 1'b0;

        // Synchronous reset; bus lines idle high so no false start
        if (!rstn) begin
            s_next        = '0;
            s_next.sclS1  = 1'b1;
            s_next.sclS2  = 1'b1;
            s_next.sclD   = 1'b1;
            s_next.sdaS1  = 1'b1;
            s_next.sdaS2  = 1'b1;
            s_next.sdaD   = 1'b1;
            s_next.fsm    = gpx_pkg::ST_IDLE;
            s_next.ctl    = {gpx_pkg::NPORT{gpx_pkg::PORT_RESET}};
            s_next.pinCfg = gpx_pkg::PINCFG_RESET;
        end
    end

    // The single state register; 1.25 us SCL half period is 50 mclk cycles
    always_ff @(posedge mclk) begin
        s_reg <= s_next;
    end

    assign sdaOut   = s_reg.sdaO;
    assign sdaOe    = s_reg.sdaE;
    assign portOut  = s_reg.portO;
    assign portOe   = s_reg.portE;
    assign portCtl  = s_reg.ctl;
    assign pinCfg   = s_reg.pinCfg;
    assign oscExtIn = s_reg.oscExt;

endmodule : gpx_port_config

/* File: gpx_port_config_checker.sv */
// Purpose: Concurrent checks on pin drive, clock functions and bus release.
// Assumes: Drive outputs trail the stored config by one flop.
// Notes:   SCL low time is counted on the raw pin.
`timescale 1ns/1ps
module gpx_port_config_checker #(
    parameter int DEB_CYCLES = 16,
    parameter int TMO_CYCLES = 200
) (
    input wire logic               mclk,
    input wire logic               rstn,
    input wire logic               scl,
    input wire logic               sdaOut,
    input wire logic               sdaOe,
    input wire logic               oscClk,
    input wire gpx_pkg::gpx_pvec_t portOut,
    input wire gpx_pkg::gpx_pvec_t portOe,
    input wire gpx_pkg::gpx_ctl_t  portCtl,
    input wire logic [7:0]         pinCfg,
    input wire logic               oscExtIn
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [15:0] lowCnt;

    // Length of the current SCL low phase, saturating
    always_ff @(posedge mclk) begin
        if (!rstn || scl) begin
            lowCnt <= 16'h0000;
        end else if (lowCnt != 16'hFFFF) begin
            lowCnt <= lowCnt + 16'h0001;
        end
    end

    sequence clkInHeld;
        !pinCfg[2] [*2];
    endsequence
    sequence clkOutSteady;
        (!pinCfg[3] && $stable(oscClk)) [*5];
    endsequence

    sda_open_drain_a: assert property (sdaOe |-> !sdaOut)
        else $error("data line driven high");
    port_one_od_a: assert property (portOe[0] |-> !portOut[0])
        else $error("port one driven high");
    clk_in_float_a: assert property (clkInHeld |-> !portOe[1])
        else $error("clock input pin driven");
    clk_in_off_a: assert property (pinCfg[2] [*2] |-> !oscExtIn)
        else $error("clock input active while GPIO");
    clk_out_a: assert property (clkOutSteady |-> portOe[2] && portOut[2] == oscClk)
        else $error("port three not carrying clock");
    input_hiz_a: assert property (portCtl[3][7] [*2] |-> !portOe[3])
        else $error("input port driven");
    push_pull_a: assert property ((portCtl[3][7:6] == 2'b01) [*2] |-> portOe[3])
        else $error("push-pull output not driven");
    open_drain_a: assert property ((portCtl[3][7:6] == 2'b00) [*2] |-> !(portOe[3] && portOut[3]))
        else $error("open-drain output driven high");
    bus_timeout_a: assert property (!pinCfg[7] && lowCnt > TMO_CYCLES + 8 |-> !sdaOe)
        else $error("bus not released after timeout");
endmodule : gpx_port_config_checker

bind gpx_port_config gpx_port_config_checker #(
    .DEB_CYCLES(DEB_CYCLES),
    .TMO_CYCLES(TMO_CYCLES)
) u_gpx_port_config_checker (.mclk, .rstn, .scl, .sdaOut, .sdaOe, .oscClk, .portOut,
    .portOe, .portCtl, .pinCfg, .oscExtIn);

/* File: gpx_port_config_tb.sv */
// Purpose: Self-checking bench for the expander port and config block.
// Assumes: Host model at 400kHz; debounce and timeout counts shortened.
// Notes:   Address-select pin strapped low, high, to SCL or to SDA.
`timescale 1ns/1ps
module gpx_port_config_tb;
    logic               mclk, rstn, oscClk, scl, sdaLine, sdaOut, sdaOe, addrSelPin, oscExtIn;
    logic [1:0]         selMode;
    logic [6:0]         dev;
    logic [7:0]         pinCfg;
    gpx_pkg::gpx_pvec_t portIn, pwmLevel, portOut, portOe;
    gpx_pkg::gpx_ctl_t  portCtl;
    int                 errors, nChecks;

    always #12.5 mclk = !mclk;
    // Slow oscillator stand-in, unrelated to the bus
    always begin
        repeat (20) @(posedge mclk);
        oscClk <= !oscClk;
    end
    assign addrSelPin = selMode[1] ? (selMode[0] ? sdaLine : scl) : selMode[0];

    gpx_i2c_host u_gpx_i2c_host (.mclk(mclk), .sdaOe(sdaOe), .sdaOut(sdaOut), .scl(scl),
        .sdaLine(sdaLine));
    gpx_port_config #(.DEB_CYCLES(16), .TMO_CYCLES(200)) u_gpx_port_config (.mclk(mclk),
        .rstn(rstn), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addrSelPin(addrSelPin), .oscClk(oscClk), .portIn(portIn), .pwmLevel(pwmLevel),
        .portOut(portOut), .portOe(portOe), .portCtl(portCtl), .pinCfg(pinCfg),
        .oscExtIn(oscExtIn));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    // Write one register; a stall holds SCL low before the data byte
    task automatic wr(input logic [7:0] ra, input logic [7:0] d, input int stall,
                      input logic expAck);
        logic [7:0] rx;
        logic a;
        u_gpx_i2c_host.start();
        u_gpx_i2c_host.xfer({dev, 1'b0}, 1'b1, rx, a);
        chk({7'h00, a}, {7'h00, !expAck});
        u_gpx_i2c_host.xfer(ra, 1'b1, rx, a);
        tick(stall);
        u_gpx_i2c_host.xfer(d, 1'b1, rx, a);
        u_gpx_i2c_host.stop();
    endtask : wr

    // Set the pointer, repeated start, read one byte with a final NACK
    task automatic rdc(input logic [7:0] ra, input logic [7:0] exp);
        logic [7:0] rx;
        logic a;
        u_gpx_i2c_host.start();
        u_gpx_i2c_host.xfer({dev, 1'b0}, 1'b1, rx, a);
        u_gpx_i2c_host.xfer(ra, 1'b1, rx, a);
        u_gpx_i2c_host.start();
        u_gpx_i2c_host.xfer({dev, 1'b1}, 1'b1, rx, a);
        u_gpx_i2c_host.xfer(8'hFF, 1'b1, rx, a);
        u_gpx_i2c_host.stop();
        chk(rx, exp);
    endtask : rdc

    task automatic report_and_stop();
        if (errors == 0 && nChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // Guard against a hung run
    initial begin
        #2400000;
        errors++;
        report_and_stop();
    end

    initial begin
        {mclk, rstn, oscClk, selMode, errors, nChecks} = '0;
        portIn = '0;
        pwmLevel = '0;
        dev = {gpx_pkg::ADDR_PREFIX, 2'h0};
        tick(16);
        rstn <= 1'b1;
        tick(4);
        chk(pinCfg, 8'h8F);
        for (int i = 0; i < 9; i++) chk(portCtl[i], 8'h80);
        rdc(8'h01, 8'h80);
        // Every strapping of the select pin, changed between transfers
        for (int s = 0; s < 4; s++) begin
            selMode <= s[1:0];
            dev = {gpx_pkg::ADDR_PREFIX, s[1:0]};
            wr(8'h04, {6'h10, s[1:0]}, 0, 1'b1);
            chk(portCtl[3], {6'h10, s[1:0]});
        end
        dev = 7'h2F;
        wr(8'h04, 8'h1F, 0, 1'b0);
        chk(portCtl[3], 8'h43);
        dev = {gpx_pkg::ADDR_PREFIX, 2'h3};
        // Output ports: push-pull and open-drain drive type, port one sink-only
        wr(8'h04, 8'h55, 0, 1'b1);
        rdc(8'h04, 8'h55);
        pwmLevel <= 9'h008;
        tick(10);
        chk({6'h00, portOe[3], portOut[3]}, 8'h03);
        wr(8'h04, 8'h35, 0, 1'b1);
        chk(portCtl[3], 8'h35);
        chk({7'h00, portOe[3]}, 8'h00);
        wr(8'h01, 8'h40, 0, 1'b1);
        pwmLevel <= 9'h001;
        tick(10);
        chk({7'h00, portOe[0]}, 8'h00);
        pwmLevel <= 9'h000;
        // Input status bits, transition flag and clear on read
        wr(8'h06, 8'h83, 0, 1'b1);
        rdc(8'h06, 8'h80);
        portIn <= 9'h020;
        tick(10);
        rdc(8'h06, 8'h83);
        rdc(8'h06, 8'h81);
        // Debounce hides a short glitch and passes a steady level
        wr(8'h07, 8'hC4, 0, 1'b1);
        portIn <= 9'h060;
        tick(3);
        portIn <= 9'h020;
        rdc(8'h07, 8'hC4);
        portIn <= 9'h060;
        tick(60);
        rdc(8'h07, 8'hC7);
        // Port one as interrupt output, D0 kept clear
        wr(8'h27, 8'h8C, 0, 1'b1);
        wr(8'h06, 8'hA0, 0, 1'b1);
        portIn <= 9'h040;
        tick(10);
        chk({6'h00, portOe[0], portOut[0]}, 8'h02);
        rdc(8'h06, 8'hA2);
        chk({7'h00, portOe[0]}, 8'h00);
        portIn <= 9'h000;
        tick(60);
        chk({7'h00, portOe[0]}, 8'h00);
        // Clock input and clock output functions override the port registers
        wr(8'h02, 8'h40, 0, 1'b1);
        wr(8'h27, 8'h82, 0, 1'b1);
        portIn <= 9'h002;
        tick(10);
        chk({6'h00, portOe[1], oscExtIn}, 8'h01);
        chk({7'h00, portOe[2]}, 8'h01);
        rdc(8'h20, 8'h00);
        // Bus timeout enabled drops a stalled write, disabled keeps it
        wr(8'h27, 8'h0E, 0, 1'b1);
        wr(8'h04, 8'h11, 300, 1'b1);
        chk(portCtl[3], 8'h35);
        wr(8'h27, 8'h8E, 0, 1'b1);
        wr(8'h04, 8'h11, 300, 1'b1);
        chk(portCtl[3], 8'h11);
        report_and_stop();
    end
endmodule : gpx_port_config_tb
